/* File: src/step_atten_consts.svh */
`ifndef STEP_ATTEN_CONSTS_SVH
`define STEP_ATTEN_CONSTS_SVH

`define SYNC_STAGES        2
`define LOAD_CNT_W         16
`define AXI_ADDR_W         4

`define REG_CTRL_OFS       4'h0
`define REG_STATUS_OFS     4'h4
`define REG_LOAD_COUNT_OFS 4'h8

`define CTRL_CNT_CLEAR_BIT 0
`define CTRL_PRESET_BIT    1

`define STAT_FINE_LSB      0
`define STAT_COARSE_LSB    4
`define STAT_OVR_BIT       8
`define STAT_HPF_BIT       9
`define STAT_LOCAL_BIT     10
`define STAT_PHASE_LSB     11

`define COARSE_RESET       4'he
`define OVR_RESET          1'b0
`define FINE_RESET         4'h0

`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

/* File: src/step_atten_pkg.sv */
`include "step_atten_consts.svh"

package step_atten_pkg;

	typedef enum logic [1:0] {
		PH_FINE   = 2'b00,
		PH_COARSE = 2'b01,
		PH_OVR    = 2'b10
	} load_phase_t;

	typedef struct packed {
		logic [3:0]             fine_reg;
		logic [3:0]             coarse_reg;
		logic                   ovr_reg;
		load_phase_t            phase_reg;
		logic                   strb_d_reg;
		logic                   rst_d_reg;
		logic [`LOAD_CNT_W-1:0] load_cnt_reg;
		logic [3:0]             fine_o_reg;
		logic [3:0]             coarse_o_reg;
		logic [3:0]             drive_o_reg;
		logic                   ovr_o_reg;
		logic                   hpf_o_reg;
		logic                   awready_reg;
		logic [`AXI_ADDR_W-1:0] aw_addr_reg;
		logic                   wready_reg;
		logic [31:0]            w_data_reg;
		logic                   w_lane0_reg;
		logic                   bvalid_reg;
		logic [1:0]             bresp_reg;
		logic                   arready_reg;
		logic                   rvalid_reg;
		logic [31:0]            rdata_reg;
		logic [1:0]             rresp_reg;
	} ctrl_state_t;

endpackage

/* File: src/pin_sync.sv */
`timescale 1ns/1ns
`default_nettype none

module pin_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             rstn_i,
	input  wire logic             ce_i,
	// Pins
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);

	typedef struct packed {
		logic [WIDTH-1:0] first_reg;
		logic [WIDTH-1:0] second_reg;
	} sync_state_t;

	sync_state_t r_reg;
	sync_state_t r_next;

	// First stage feeds only the second stage
	always_comb begin
		r_next            = r_reg;
		r_next.first_reg  = async_i;
		r_next.second_reg = r_reg.first_reg;
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			r_reg <= '0;
		end else if (ce_i) begin
			r_reg <= r_next;
		end
	end

	assign sync_o = r_reg.second_reg;

endmodule // pin_sync

`default_nettype wire

/* File: src/step_atten_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none

`include "step_atten_consts.svh"

module step_atten_ctrl (
	// Clock, reset, enable
	input  wire logic                   CLK_SYS_I,
	input  wire logic                   RSTN_I,
	input  wire logic                   CE_I,
	// Mode and host strobes
	input  wire logic                   LOCAL_REMOTE_SELECT_I,
	input  wire logic                   ATTEN_LOAD_STROBE_I,
	input  wire logic                   REMOTE_RESET_N_I,
	// Host program data
	input  wire logic                   PROG_DATA_WEIGHT_ONE_I,
	input  wire logic                   PROG_DATA_WEIGHT_TWO_I,
	input  wire logic                   PROG_DATA_WEIGHT_FOUR_I,
	input  wire logic                   PROG_DATA_WEIGHT_EIGHT_I,
	// Front-panel range switch
	input  wire logic [3:0]             RANGE_CODE_I,
	input  wire logic                   RANGE_OVERRANGE_I,
	// Host frequency digits
	input  wire logic [3:0]             FREQ_DIGIT_100M_I,
	input  wire logic [3:0]             FREQ_DIGIT_1G_I,
	// Coarse selections
	output logic                        COARSE_SEL_TEN_O,
	output logic                        COARSE_SEL_TWENTY_O,
	output logic                        COARSE_SEL_FORTY_O,
	output logic                        COARSE_SEL_EIGHTY_O,
	output logic                        OVERRANGE_SEL_O,
	// Fine selections
	output logic                        FINE_SEL_ONE_O,
	output logic                        FINE_SEL_TWO_O,
	output logic                        FINE_SEL_FOUR_O,
	output logic                        FINE_SEL_EIGHT_O,
	// Relay drives and filter
	output logic                        COARSE_DRIVE_TEN_O,
	output logic                        COARSE_DRIVE_TWENTY_O,
	output logic                        COARSE_DRIVE_FORTY_O,
	output logic                        COARSE_DRIVE_EIGHTY_O,
	output logic                        HPF_ENABLE_O,
	// AXI4-Lite write
	input  wire logic [`AXI_ADDR_W-1:0] AWADDR_I,
	input  wire logic                   AWVALID_I,
	output logic                        AWREADY_O,
	input  wire logic [31:0]            WDATA_I,
	input  wire logic [3:0]             WSTRB_I,
	input  wire logic                   WVALID_I,
	output logic                        WREADY_O,
	output logic [1:0]                  BRESP_O,
	output logic                        BVALID_O,
	input  wire logic                   BREADY_I,
	// AXI4-Lite read
	input  wire logic [`AXI_ADDR_W-1:0] ARADDR_I,
	input  wire logic                   ARVALID_I,
	output logic                        ARREADY_O,
	output logic [31:0]                 RDATA_O,
	output logic [1:0]                  RRESP_O,
	output logic                        RVALID_O,
	input  wire logic                   RREADY_I
);

	import step_atten_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	localparam int PIN_W = 20;

	logic [PIN_W-1:0] pins_async;
	logic [PIN_W-1:0] pins_sync;
	logic             local_mode;
	logic             strobe_s;
	logic             rst_n_s;
	logic [3:0]       prog_data;
	logic [3:0]       range_code;
	logic             range_ovr;
	logic [3:0]       digit_100m;
	logic [3:0]       digit_1g;

	assign pins_async = {LOCAL_REMOTE_SELECT_I, ATTEN_LOAD_STROBE_I, REMOTE_RESET_N_I,
		PROG_DATA_WEIGHT_EIGHT_I, PROG_DATA_WEIGHT_FOUR_I, PROG_DATA_WEIGHT_TWO_I,
		PROG_DATA_WEIGHT_ONE_I, RANGE_CODE_I, RANGE_OVERRANGE_I, FREQ_DIGIT_100M_I,
		FREQ_DIGIT_1G_I};

	pin_sync #(
		.WIDTH (PIN_W)
	) u_pin_sync (
		.clk_i   (CLK_SYS_I),
		.rstn_i  (RSTN_I),
		.ce_i    (CE_I),
		.async_i (pins_async),
		.sync_o  (pins_sync)
	);

	assign {local_mode, strobe_s, rst_n_s, prog_data, range_code, range_ovr,
		digit_100m, digit_1g} = pins_sync;

	////////////////////////////////////////////////////////////////////////////////
	// State

	ctrl_state_t r_reg;
	ctrl_state_t r_next;

	logic        strobe_rise;
	logic        reset_fall;
	logic        soft_preset;
	logic        cnt_clear;
	logic        loaded;
	logic [31:0] status_word;

	always_comb begin
		r_next      = r_reg;
		soft_preset = 1'b0;
		cnt_clear   = 1'b0;
		loaded      = 1'b0;

		// Edges are taken from settled copies only
		strobe_rise       = strobe_s & ~r_reg.strb_d_reg;
		reset_fall        = r_reg.rst_d_reg & ~rst_n_s;
		r_next.strb_d_reg = strobe_s;
		r_next.rst_d_reg  = rst_n_s;

		// Write channel: address and data accepted in either order
		if (AWVALID_I && r_reg.awready_reg) begin
			r_next.awready_reg = 1'b0;
			r_next.aw_addr_reg = AWADDR_I;
		end
		if (WVALID_I && r_reg.wready_reg) begin
			r_next.wready_reg  = 1'b0;
			r_next.w_data_reg  = WDATA_I;
			r_next.w_lane0_reg = WSTRB_I[0];
		end
		if (!r_reg.awready_reg && !r_reg.wready_reg && !r_reg.bvalid_reg) begin
			r_next.awready_reg = 1'b1;
			r_next.wready_reg  = 1'b1;
			r_next.bvalid_reg  = 1'b1;
			r_next.bresp_reg   = `RESP_SLVERR;
			unique case (r_reg.aw_addr_reg)
				`REG_CTRL_OFS: begin
					r_next.bresp_reg = `RESP_OKAY;
					if (r_reg.w_lane0_reg) begin
						cnt_clear   = r_reg.w_data_reg[`CTRL_CNT_CLEAR_BIT];
						soft_preset = r_reg.w_data_reg[`CTRL_PRESET_BIT];
					end
				end
				`REG_STATUS_OFS, `REG_LOAD_COUNT_OFS: begin
					r_next.bresp_reg = `RESP_OKAY;
				end
				default: begin
					r_next.bresp_reg = `RESP_SLVERR;
				end
			endcase
		end
		if (r_reg.bvalid_reg && BREADY_I) begin
			r_next.bvalid_reg = 1'b0;
		end

		// Remote storage: changes only on preset, host reset or a strobe
		if (reset_fall || soft_preset) begin
			r_next.coarse_reg = `COARSE_RESET;
			r_next.ovr_reg    = `OVR_RESET;
			r_next.phase_reg  = PH_FINE;
		end else if (!local_mode && strobe_rise) begin
			// Three strobes per setting: fine, then coarse, then overrange
			loaded = 1'b1;
			unique case (r_reg.phase_reg)
				PH_FINE: begin
					r_next.fine_reg  = prog_data;
					r_next.phase_reg = PH_COARSE;
				end
				PH_COARSE: begin
					r_next.coarse_reg = prog_data;
					r_next.phase_reg  = PH_OVR;
				end
				PH_OVR: begin
					r_next.ovr_reg   = prog_data[0];
					r_next.phase_reg = PH_FINE;
				end
				default: begin
					r_next.phase_reg = PH_FINE;
				end
			endcase
		end

		// A load in the clearing cycle still counts
		if (cnt_clear) begin
			r_next.load_cnt_reg = '0;
		end
		if (loaded) begin
			r_next.load_cnt_reg = r_next.load_cnt_reg + 1'b1;
		end

		// Output selection, high inserts a step
		if (local_mode) begin
			r_next.coarse_o_reg = range_code;
			r_next.ovr_o_reg    = range_ovr;
			r_next.fine_o_reg   = `FINE_RESET;
		end else begin
			r_next.coarse_o_reg = r_next.coarse_reg;
			r_next.ovr_o_reg    = r_next.ovr_reg;
			r_next.fine_o_reg   = r_next.fine_reg;
		end
		r_next.drive_o_reg = r_next.coarse_o_reg;
		// Only two digits are seen, so the threshold falls at the 100 MHz digit
		r_next.hpf_o_reg = (digit_1g != 4'h0) || (digit_100m != 4'h0);

		// Read channel
		status_word = '0;
		status_word[`STAT_FINE_LSB +: 4]   = r_reg.fine_o_reg;
		status_word[`STAT_COARSE_LSB +: 4] = r_reg.coarse_o_reg;
		status_word[`STAT_OVR_BIT]         = r_reg.ovr_o_reg;
		status_word[`STAT_HPF_BIT]         = r_reg.hpf_o_reg;
		status_word[`STAT_LOCAL_BIT]       = local_mode;
		status_word[`STAT_PHASE_LSB +: 2]  = r_reg.phase_reg;
		if (ARVALID_I && r_reg.arready_reg) begin
			r_next.arready_reg = 1'b0;
			r_next.rvalid_reg  = 1'b1;
			r_next.rresp_reg   = `RESP_OKAY;
			unique case (ARADDR_I)
				`REG_CTRL_OFS:       r_next.rdata_reg = '0;
				`REG_STATUS_OFS:     r_next.rdata_reg = status_word;
				`REG_LOAD_COUNT_OFS: r_next.rdata_reg = {{(32-`LOAD_CNT_W){1'b0}},
					r_reg.load_cnt_reg};
				default: begin
					r_next.rdata_reg = '0;
					r_next.rresp_reg = `RESP_SLVERR;
				end
			endcase
		end
		if (r_reg.rvalid_reg && RREADY_I) begin
			r_next.rvalid_reg  = 1'b0;
			r_next.arready_reg = 1'b1;
		end
	end

	always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			r_reg             <= '0;
			r_reg.coarse_reg  <= `COARSE_RESET;
			r_reg.ovr_reg     <= `OVR_RESET;
			r_reg.fine_reg    <= `FINE_RESET;
			r_reg.phase_reg   <= PH_FINE;
			// Edge history starts low like the cleared synchroniser: no false reset edge
			r_reg.awready_reg <= 1'b1;
			r_reg.wready_reg  <= 1'b1;
			r_reg.arready_reg <= 1'b1;
		end else if (CE_I) begin
			r_reg <= r_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign {COARSE_SEL_EIGHTY_O, COARSE_SEL_FORTY_O, COARSE_SEL_TWENTY_O,
		COARSE_SEL_TEN_O} = r_reg.coarse_o_reg;
	assign OVERRANGE_SEL_O = r_reg.ovr_o_reg;
	assign {FINE_SEL_EIGHT_O, FINE_SEL_FOUR_O, FINE_SEL_TWO_O, FINE_SEL_ONE_O} = r_reg.fine_o_reg;
	assign {COARSE_DRIVE_EIGHTY_O, COARSE_DRIVE_FORTY_O, COARSE_DRIVE_TWENTY_O,
		COARSE_DRIVE_TEN_O} = r_reg.drive_o_reg;
	assign HPF_ENABLE_O = r_reg.hpf_o_reg;
	assign AWREADY_O    = r_reg.awready_reg;
	assign WREADY_O     = r_reg.wready_reg;
	assign BVALID_O     = r_reg.bvalid_reg;
	assign BRESP_O      = r_reg.bresp_reg;
	assign ARREADY_O    = r_reg.arready_reg;
	assign RVALID_O     = r_reg.rvalid_reg;
	assign RDATA_O      = r_reg.rdata_reg;
	assign RRESP_O      = r_reg.rresp_reg;

endmodule // step_atten_ctrl

`default_nettype wire

/* File: verification/step_atten_ctrl_checker.sv */
`timescale 1ns/1ns
`default_nettype none

module step_atten_ctrl_checker (
	// Clock and reset
	input wire logic       CLK_SYS_I, RSTN_I, CE_I,
	// Pins
	input wire logic       LOCAL_REMOTE_SELECT_I, ATTEN_LOAD_STROBE_I, REMOTE_RESET_N_I,
	input wire logic [3:0] RANGE_CODE_I, FREQ_DIGIT_100M_I, FREQ_DIGIT_1G_I,
	input wire logic       RANGE_OVERRANGE_I,
	// Selections
	input wire logic       COARSE_SEL_TEN_O, COARSE_SEL_TWENTY_O, COARSE_SEL_FORTY_O,
	input wire logic       COARSE_SEL_EIGHTY_O, OVERRANGE_SEL_O, HPF_ENABLE_O,
	input wire logic       FINE_SEL_ONE_O, FINE_SEL_TWO_O, FINE_SEL_FOUR_O, FINE_SEL_EIGHT_O,
	input wire logic       COARSE_DRIVE_TEN_O, COARSE_DRIVE_TWENTY_O,
	input wire logic       COARSE_DRIVE_FORTY_O, COARSE_DRIVE_EIGHTY_O,
	// Bus handshakes
	input wire logic       AWVALID_I, AWREADY_O, WVALID_I, WREADY_O, BVALID_O,
	input wire logic       ARVALID_I, ARREADY_O, RVALID_O
);
	wire logic [3:0] sel = {COARSE_SEL_EIGHTY_O, COARSE_SEL_FORTY_O, COARSE_SEL_TWENTY_O,
		COARSE_SEL_TEN_O};
	wire logic [3:0] drv = {COARSE_DRIVE_EIGHTY_O, COARSE_DRIVE_FORTY_O, COARSE_DRIVE_TWENTY_O,
		COARSE_DRIVE_TEN_O};
	wire logic [3:0] fine = {FINE_SEL_EIGHT_O, FINE_SEL_FOUR_O, FINE_SEL_TWO_O, FINE_SEL_ONE_O};

	default clocking @(posedge CLK_SYS_I); endclocking
	default disable iff (!RSTN_I);

	////////////////////////////////////////////////////////////////////////////////
	// Five quiet enabled cycles cover the sync flops, the output flop and reset release
	sequence s_local_steady;
		(LOCAL_REMOTE_SELECT_I && CE_I && $stable(RANGE_CODE_I)
			&& $stable(RANGE_OVERRANGE_I))[*5];
	endsequence
	sequence s_quiet_remote;
		(!LOCAL_REMOTE_SELECT_I && !ATTEN_LOAD_STROBE_I && REMOTE_RESET_N_I && !AWVALID_I)[*5];
	endsequence
	sequence s_host_reset;
		$fell(REMOTE_RESET_N_I) && !LOCAL_REMOTE_SELECT_I
		##1 (!LOCAL_REMOTE_SELECT_I && !ATTEN_LOAD_STROBE_I)[*3];
	endsequence

	////////////////////////////////////////////////////////////////////////////////
	a_drive_mirror: assert property (drv == sel)
		else $error("Relay drive differs from selection");
	a_local_follow: assert property (s_local_steady |->
		{OVERRANGE_SEL_O, sel} == {RANGE_OVERRANGE_I, RANGE_CODE_I})
		else $error("Local selection differs from range switch");
	a_fine_local: assert property (LOCAL_REMOTE_SELECT_I[*4] |-> fine == 4'h0)
		else $error("Fine selection active in local mode");
	a_hpf_decode: assert property (
		($stable(FREQ_DIGIT_100M_I) && $stable(FREQ_DIGIT_1G_I))[*4] |->
		HPF_ENABLE_O == (FREQ_DIGIT_100M_I != 4'h0 || FREQ_DIGIT_1G_I != 4'h0))
		else $error("Filter enable wrong for digits");
	a_remote_hold: assert property (s_quiet_remote |->
		$stable(sel) && $stable(fine) && $stable(OVERRANGE_SEL_O))
		else $error("Stored selection changed without strobe");
	a_reset_max: assert property (s_host_reset |-> sel == 4'he && !OVERRANGE_SEL_O)
		else $error("Host reset did not set maximum attenuation");
	a_write_resp: assert property (AWVALID_I && AWREADY_O && WVALID_I && WREADY_O && !BVALID_O
		|-> ##2 BVALID_O)
		else $error("Write response late");
	a_aw_busy: assert property (AWVALID_I && AWREADY_O |=> !AWREADY_O)
		else $error("Write address ready while busy");
	a_read_resp: assert property (ARVALID_I && ARREADY_O |=> RVALID_O)
		else $error("Read response late");
endmodule // step_atten_ctrl_checker

bind step_atten_ctrl step_atten_ctrl_checker step_atten_ctrl_checker_inst (.*);

`default_nettype wire

/* File: verification/host_model.sv */
`timescale 1ns/1ns
`default_nettype none

module host_model (
	input  wire logic       clk_i,
	output var  logic       mode_o,
	output var  logic       strobe_o,
	output var  logic       rstn_o,
	output var  logic [3:0] data_o,
	output var  logic [3:0] d100_o,
	output var  logic [3:0] d1g_o
);
	initial begin
		mode_o = 1'b1;
		strobe_o = 1'b0;
		rstn_o = 1'b1;
		data_o = 4'h0;
		d100_o = 4'h0;
		d1g_o = 4'h0;
	end

	// Data settles well before the strobe so the sync flops see it steady
	task automatic load(input logic [3:0] v);
		@(posedge clk_i) data_o <= v;
		repeat (4) @(posedge clk_i);
		strobe_o <= 1'b1;
		repeat (3) @(posedge clk_i);
		strobe_o <= 1'b0;
		data_o <= ~v; // Lines left to wander once the strobe is gone
		repeat (4) @(posedge clk_i);
	endtask

	task automatic pulse_reset;
		@(posedge clk_i) rstn_o <= 1'b0;
		repeat (3) @(posedge clk_i);
		rstn_o <= 1'b1;
		repeat (5) @(posedge clk_i);
	endtask

	task automatic set_mode(input logic m);
		@(posedge clk_i) mode_o <= m;
		repeat (5) @(posedge clk_i);
	endtask

	task automatic set_freq(input logic [3:0] a, input logic [3:0] b);
		@(posedge clk_i) d100_o <= a;
		d1g_o <= b;
		repeat (5) @(posedge clk_i);
	endtask
endmodule // host_model

`default_nettype wire

/* File: verification/tb_step_atten_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none

module tb_step_atten_ctrl;
	logic CLK_SYS_I = 1'b0, RSTN_I = 1'b0, CE_I = 1'b1, RANGE_OVERRANGE_I = 1'b0;
	logic [3:0] RANGE_CODE_I = 4'h0, AWADDR_I = 4'h0, ARADDR_I = 4'h0, WSTRB_I = 4'hf;
	logic AWVALID_I = 1'b0, WVALID_I = 1'b0, BREADY_I = 1'b0, ARVALID_I = 1'b0, RREADY_I = 1'b0;
	logic [31:0] WDATA_I = 32'h0;
	wire logic LOCAL_REMOTE_SELECT_I, ATTEN_LOAD_STROBE_I, REMOTE_RESET_N_I;
	wire logic PROG_DATA_WEIGHT_ONE_I, PROG_DATA_WEIGHT_TWO_I;
	wire logic PROG_DATA_WEIGHT_FOUR_I, PROG_DATA_WEIGHT_EIGHT_I;
	wire logic [3:0] FREQ_DIGIT_100M_I, FREQ_DIGIT_1G_I, hd;
	wire logic COARSE_SEL_TEN_O, COARSE_SEL_TWENTY_O, COARSE_SEL_FORTY_O, COARSE_SEL_EIGHTY_O;
	wire logic FINE_SEL_ONE_O, FINE_SEL_TWO_O, FINE_SEL_FOUR_O, FINE_SEL_EIGHT_O;
	wire logic COARSE_DRIVE_TEN_O, COARSE_DRIVE_TWENTY_O, COARSE_DRIVE_FORTY_O;
	wire logic COARSE_DRIVE_EIGHTY_O, OVERRANGE_SEL_O, HPF_ENABLE_O;
	wire logic AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O;
	wire logic [1:0] BRESP_O, RRESP_O;
	wire logic [31:0] RDATA_O;
	int n_fail = 0, cmp_count = 0, seed = 89, loc = 1;
	int m_fine = 0, m_coarse = 14, m_ovr = 0, m_phase = 0, m_cnt = 0;
	int prog[9] = '{7, 0, 0, 7, 7, 1, 8, 8, 1};
	int fq[6] = '{'h00, 'h10, 'h01, 'h91, 'h90, 'h09};
	logic [31:0] d;
	logic [1:0] r;

	assign {PROG_DATA_WEIGHT_EIGHT_I, PROG_DATA_WEIGHT_FOUR_I} = hd[3:2];
	assign {PROG_DATA_WEIGHT_TWO_I, PROG_DATA_WEIGHT_ONE_I} = hd[1:0];

	step_atten_ctrl step_atten_ctrl_inst (.*);
	host_model host_model_inst (.clk_i(CLK_SYS_I), .mode_o(LOCAL_REMOTE_SELECT_I),
		.strobe_o(ATTEN_LOAD_STROBE_I), .rstn_o(REMOTE_RESET_N_I), .data_o(hd),
		.d100_o(FREQ_DIGIT_100M_I), .d1g_o(FREQ_DIGIT_1G_I));

	initial begin
		forever #20 CLK_SYS_I = ~CLK_SYS_I;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic stop_test;
		$display("Compared %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk_outs;
		logic [8:0] e;
		e = loc ? {RANGE_OVERRANGE_I, RANGE_CODE_I, 4'h0} : 9'((m_ovr << 8) + (m_coarse << 4) + m_fine);
		chk("sel", 32'({OVERRANGE_SEL_O, COARSE_SEL_EIGHTY_O, COARSE_SEL_FORTY_O, COARSE_SEL_TWENTY_O,
			COARSE_SEL_TEN_O, FINE_SEL_EIGHT_O, FINE_SEL_FOUR_O, FINE_SEL_TWO_O,
			FINE_SEL_ONE_O}), 32'(e));
		chk("drive", 32'({COARSE_DRIVE_EIGHTY_O, COARSE_DRIVE_FORTY_O, COARSE_DRIVE_TWENTY_O,
			COARSE_DRIVE_TEN_O}), 32'(e[7:4]));
		chk("hpf", 32'(HPF_ENABLE_O), 32'(FREQ_DIGIT_100M_I != 0 || FREQ_DIGIT_1G_I != 0));
	endtask

	// The model only counts a nibble while remote, as the strobe is dead in local
	task automatic ld(input int v);
		host_model_inst.load(4'(v));
		if (!loc) begin
			case (m_phase)
				0: m_fine = v;
				1: m_coarse = v;
				default: m_ovr = v & 1;
			endcase
			m_phase = (m_phase + 1) % 3;
			m_cnt++;
		end
		chk_outs;
	endtask

	task automatic axi_wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rs);
		int n;
		n = 0;
		@(posedge CLK_SYS_I);
		AWADDR_I <= a;
		WDATA_I <= v;
		AWVALID_I <= 1'b1;
		WVALID_I <= 1'b1;
		BREADY_I <= 1'b1;
		do begin
			@(posedge CLK_SYS_I);
			if (AWREADY_O) AWVALID_I <= 1'b0;
			if (WREADY_O) WVALID_I <= 1'b0;
			n++;
		end while (BVALID_O !== 1'b1 && n < 50);
		rs = BRESP_O;
		BREADY_I <= 1'b0;
		if (n >= 50) begin
			n_fail++;
			stop_test;
		end
	endtask

	task automatic axi_rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
		int n;
		n = 0;
		@(posedge CLK_SYS_I);
		ARADDR_I <= a;
		ARVALID_I <= 1'b1;
		RREADY_I <= 1'b1;
		do begin
			@(posedge CLK_SYS_I);
			if (ARREADY_O) ARVALID_I <= 1'b0;
			n++;
		end while (RVALID_O !== 1'b1 && n < 50);
		v = RDATA_O;
		rs = RRESP_O;
		RREADY_I <= 1'b0;
		if (n >= 50) begin
			n_fail++;
			stop_test;
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(posedge CLK_SYS_I);
		RSTN_I <= 1'b1;
		repeat (4) @(posedge CLK_SYS_I);
		for (int i = 0; i < 5; i++) begin
			RANGE_CODE_I <= 4'($random(seed));
			RANGE_OVERRANGE_I <= 1'($random(seed));
			repeat (5) @(posedge CLK_SYS_I);
			chk_outs;
		end
		// Clock enable low must freeze the outputs although the switch moves
		CE_I <= 1'b0;
		RANGE_CODE_I <= ~RANGE_CODE_I;
		repeat (5) @(posedge CLK_SYS_I);
		chk("freeze", 32'({COARSE_SEL_EIGHTY_O, COARSE_SEL_FORTY_O, COARSE_SEL_TWENTY_O,
			COARSE_SEL_TEN_O}), 32'(4'(~RANGE_CODE_I)));
		CE_I <= 1'b1;
		repeat (5) @(posedge CLK_SYS_I);
		chk_outs;
		ld(5);
		axi_rd(4'h8, d, r);
		chk("count", d, 32'(m_cnt));
		host_model_inst.set_mode(1'b0);
		loc = 0;
		chk_outs;
		host_model_inst.pulse_reset;
		chk_outs;
		foreach (prog[i]) ld(prog[i]);
		host_model_inst.pulse_reset;
		m_coarse = 14;
		m_ovr = 0;
		m_phase = 0;
		chk_outs;
		for (int i = 0; i < 3; i++) ld($random(seed) & 15);
		axi_wr(4'h0, 32'h2, r);
		chk("wresp", 32'(r), 32'h0);
		m_coarse = 14;
		m_ovr = 0;
		m_phase = 0;
		chk_outs;
		foreach (fq[i]) begin
			host_model_inst.set_freq(4'(fq[i] >> 4), 4'(fq[i]));
			chk_outs;
		end
		axi_rd(4'h8, d, r);
		chk("count", d, 32'(m_cnt));
		axi_rd(4'h4, d, r);
		chk("status", d, 32'(m_fine + (m_coarse << 4) + (m_ovr << 8) + (1 << 9) +
			(m_phase << 11)));
		axi_wr(4'h0, 32'h1, r);
		chk("wresp", 32'(r), 32'h0);
		axi_rd(4'h8, d, r);
		chk("count", d, 32'h0);
		axi_wr(4'h4, 32'hffff, r);
		chk("wresp", 32'(r), 32'h0);
		axi_wr(4'hc, 32'h3, r);
		chk("wresp", 32'(r), 32'h2);
		axi_rd(4'hc, d, r);
		chk("rdata", d, 32'h0);
		chk("rresp", 32'(r), 32'h2);
		host_model_inst.set_mode(1'b1);
		loc = 1;
		chk_outs;
		stop_test;
	end
endmodule // tb_step_atten_ctrl

`default_nettype wire
